// ### gdc_ctrl.sv
// gate driver controller: drives pwm, enable/fault and zero-cross pins
// of a half-bridge gate driver; orders come over a plain register port.
// assumes an external pull-up on the enable/fault wire and a logic
// supply monitor giving supply_ok synchronous to clk_sys.
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps

module gdc_ctrl #(
   parameter int unsigned CNT_W = 16
) (
   input  wire logic                        clk_sys,
   input  wire logic                        sys_rst,
   input  wire logic [gdc_pkg::ADDR_W-1:0]  addr,
   input  wire logic [31:0]                 wdata,
   input  wire logic                        wr_en,
   input  wire logic                        rd_en,
   output logic      [31:0]                 rdata,
   input  wire logic                        supply_ok,
   input  wire logic                        enable_fault_pin_i,
   output logic                             enable_fault_pin_o,
   output logic                             enable_fault_pin_oe,
   output logic                             pwm_o,
   output logic                             pwm_oe,
   output logic                             zero_cross_detect_n
);

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   logic [gdc_pkg::CTRL_W-1:0] ctrl_q,   ctrl_d;
   logic [CNT_W-1:0]           period_q, period_d;
   logic [CNT_W-1:0]           ontime_q, ontime_d;
   logic [31:0]                rdata_q,  rdata_d;

   gdc_pkg::gdc_state_e        state_q,  state_d;
   logic [gdc_pkg::WAIT_W-1:0] wait_q,   wait_d;

   logic                       ctrl_en;
   logic                       ctrl_run;
   logic                       ctrl_tri;
   logic                       start_ok;

   assign ctrl_en  = ctrl_q[gdc_pkg::CTRL_EN_BIT];
   assign ctrl_run = ctrl_q[gdc_pkg::CTRL_RUN_BIT];
   assign ctrl_tri = ctrl_q[gdc_pkg::CTRL_TRI_BIT];

   always_comb begin
      ctrl_d   = ctrl_q;
      period_d = period_q;
      ontime_d = ontime_q;
      rdata_d  = 32'h0000_0000;
      if (wr_en) begin
         case (addr)
            gdc_pkg::CTRL_OFS:   ctrl_d   = wdata[gdc_pkg::CTRL_W-1:0];
            gdc_pkg::PERIOD_OFS: period_d = wdata[CNT_W-1:0];
            gdc_pkg::ONTIME_OFS: ontime_d = wdata[CNT_W-1:0];
            default: ;
         endcase
      end
      if (rd_en) begin
         case (addr)
            gdc_pkg::CTRL_OFS:   rdata_d = {28'h0000000, ctrl_q};
            gdc_pkg::PERIOD_OFS: rdata_d = 32'(period_q);
            gdc_pkg::ONTIME_OFS: rdata_d = 32'(ontime_q);
            gdc_pkg::STATUS_OFS: begin
               rdata_d = {28'h0000000, pwm_oe,
                          state_q == gdc_pkg::GDC_FAULT,
                          state_q == gdc_pkg::GDC_RUN, supply_ok};
            end
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ctrl_q   <= gdc_pkg::CTRL_RST;
         period_q <= CNT_W'(gdc_pkg::PERIOD_RST);
         ontime_q <= CNT_W'(gdc_pkg::ONTIME_RST);
         rdata_q  <= 32'h0000_0000;
      end else begin
         ctrl_q   <= ctrl_d;
         period_q <= period_d;
         ontime_q <= ontime_d;
         rdata_q  <= rdata_d;
      end
   end

   assign rdata = rdata_q;

   // ----------------------------------------------------------------
   // startup sequencer
   // ----------------------------------------------------------------
   // the wait starts only once supply, our enable and the pin level
   // agree, so any order in which they arrive gives the full delay
   assign start_ok = supply_ok & ctrl_en & enable_fault_pin_i;

   always_comb begin
      state_d = state_q;
      wait_d  = wait_q;
      unique case (state_q)
         gdc_pkg::GDC_OFF: begin
            wait_d = '0;
            if (start_ok) begin
               state_d = gdc_pkg::GDC_WAIT;
            end
         end
         gdc_pkg::GDC_WAIT: begin
            if (!start_ok) begin
               state_d = gdc_pkg::GDC_OFF;
               wait_d  = '0;
            end else if (wait_q == gdc_pkg::WAIT_W'(gdc_pkg::STARTUP_CYC - 1))
            begin
               state_d = gdc_pkg::GDC_RUN;
            end else begin
               wait_d = gdc_pkg::WAIT_W'(wait_q + 1'b1);
            end
         end
         gdc_pkg::GDC_RUN: begin
            if (!supply_ok || !ctrl_en) begin
               state_d = gdc_pkg::GDC_OFF;
            end else if (!enable_fault_pin_i) begin
               // pin released by us yet low: the driver flags a fault
               state_d = gdc_pkg::GDC_FAULT;
            end
         end
         gdc_pkg::GDC_FAULT: begin
            // the driver only restarts after a supply power cycle
            if (!supply_ok) begin
               state_d = gdc_pkg::GDC_OFF;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_q <= gdc_pkg::GDC_OFF;
         wait_q  <= '0;
      end else begin
         state_q <= state_d;
         wait_q  <= wait_d;
      end
   end

   // ----------------------------------------------------------------
   // pin drive
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic             pwm_q, pwm_d;
   logic             pwm_oe_q, pwm_oe_d;
   logic             en_oe_q, en_oe_d;
   logic             zcd_q, zcd_d;
   logic             switching;

   assign switching = (state_q == gdc_pkg::GDC_RUN) & ctrl_run & ~ctrl_tri;

   always_comb begin
      cnt_d = '0;
      pwm_d = 1'b0;
      // floating pwm sits in the driver window; used during startup,
      // faults and phase shedding, and whenever the supply is absent
      pwm_oe_d = switching & supply_ok;
      if (switching) begin
         cnt_d = (cnt_q >= period_q - 1'b1) ? '0 : CNT_W'(cnt_q + 1'b1);
         pwm_d = cnt_q < ontime_q;
      end
      // open-drain style: release for enable, the pull-up raises it
      // follows the stored enable, so the pin is never pulled low while
      // the sequencer still counts itself running
      en_oe_d = ~ctrl_q[gdc_pkg::CTRL_EN_BIT];
      zcd_d   = ctrl_q[gdc_pkg::CTRL_ZCD_BIT];
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cnt_q    <= '0;
         pwm_q    <= 1'b0;
         pwm_oe_q <= 1'b0;
         en_oe_q  <= 1'b1;
         zcd_q    <= 1'b1;
      end else begin
         cnt_q    <= cnt_d;
         pwm_q    <= pwm_d;
         pwm_oe_q <= pwm_oe_d;
         en_oe_q  <= en_oe_d;
         zcd_q    <= zcd_d;
      end
   end

   assign pwm_o               = pwm_q;
   assign pwm_oe              = pwm_oe_q;
   assign enable_fault_pin_o  = 1'b0;
   assign enable_fault_pin_oe = en_oe_q;
   assign zero_cross_detect_n = zcd_q;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   a_pwm_no_supply: assert property (
      !supply_ok |=> !pwm_oe)
      else $error("pwm driven without logic supply");

   a_startup_float: assert property (
      state_q == gdc_pkg::GDC_WAIT |=> !pwm_oe)
      else $error("pwm driven during driver startup");

   a_startup_delay: assert property (
      (state_q == gdc_pkg::GDC_RUN && $past(state_q) != gdc_pkg::GDC_RUN)
      |-> ($past(state_q) == gdc_pkg::GDC_WAIT &&
           $past(wait_q) == gdc_pkg::WAIT_W'(gdc_pkg::STARTUP_CYC - 1)))
      else $error("run entered without full startup wait");

   a_enable_release: assert property (
      state_q == gdc_pkg::GDC_RUN |-> !enable_fault_pin_oe)
      else $error("enable pin held low while running");

   a_disable_drive: assert property (
      (wr_en && addr == gdc_pkg::CTRL_OFS &&
       !wdata[gdc_pkg::CTRL_EN_BIT])
      |=> ##1 (enable_fault_pin_oe && !enable_fault_pin_o))
      else $error("enable pin not pulled low on disable");

   a_fault_stop: assert property (
      state_q == gdc_pkg::GDC_FAULT |=> !pwm_oe ##1 !pwm_oe)
      else $error("pwm driven after fault");

endmodule // gdc_ctrl

// ### gdc_ctrl_tb_top.sv
// self-checking bench for the gate driver controller
// assumes a pull-up on the enable/fault wire and the device model beside it
`timescale 1ns/1ps
module gdc_ctrl_tb_top;
   logic clk_sys = 0, sys_rst = 1, wr_en = 0, rd_en = 0, supply_ok = 0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic efp_o, efp_oe, pwm_o, pwm_oe, zcd_n, en_wire;
   logic hg, lg, flt, neg, il_pos = 1, hs_fault = 0;
   int error_cnt = 0, tests_run = 0, n;
   // pull-up wins unless either party pulls low
   assign en_wire = (efp_oe || flt) ? 1'b0 : 1'b1;
   gdc_ctrl dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
      .supply_ok(supply_ok), .enable_fault_pin_i(en_wire),
      .enable_fault_pin_o(efp_o), .enable_fault_pin_oe(efp_oe),
      .pwm_o(pwm_o), .pwm_oe(pwm_oe), .zero_cross_detect_n(zcd_n));
   gdc_drv_model drv_u (.clk_sys(clk_sys), .supply_ok(supply_ok),
      .en_wire(en_wire), .pwm_lvl(pwm_o), .pwm_drv(pwm_oe), .zcd_n(zcd_n),
      .il_pos(il_pos), .hs_fault(hs_fault), .high_gate(hg),
      .low_gate(lg), .flt_oe(flt), .neg_mode(neg));
   initial begin
      forever #2.5 clk_sys = ~clk_sys;
   end
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk_sys);
      wr_en <= 1'b0;
      #1;
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] e, string nm);
      @(posedge clk_sys);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1 chk(nm, e, rdata);
   endtask
   // counts cycles until pwm is driven; gates must stay low meanwhile
   task automatic wait_run();
      n = 0;
      while (pwm_oe !== 1'b1 && n < 5000) begin
         if (hg !== 1'b0 || lg !== 1'b0) chk("gates_in_startup", 0, 1);
         cyc(1);
         n++;
      end
      chk("startup_late", 1, n <= gdc_pkg::STARTUP_CYC + 4);
      chk("startup_early", 1, n >= gdc_pkg::STARTUP_CYC);
   endtask
   task automatic wait_lvl(logic v);
      n = 0;
      while (pwm_o !== v && n < 100) begin
         cyc(1);
         n++;
      end
      chk("pwm_level", 32'(v), 32'(pwm_o));
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      chk("oe_rst", 1, efp_oe);
      chk("od_data", 0, efp_o);
      chk("pwm_oe_rst", 0, pwm_oe);
      rd(gdc_pkg::CTRL_OFS, 32'h8, "ctrl_rst");
      rd(gdc_pkg::PERIOD_OFS, 32'hC8, "period_rst");
      rd(gdc_pkg::ONTIME_OFS, 32'h14, "ontime_rst");
      rd(8'h10, 32'h0, "unmapped");
      wr(gdc_pkg::STATUS_OFS, 32'hF);
      rd(gdc_pkg::STATUS_OFS, 32'h0, "status_ro");
   endtask
   task automatic t_run();
      @(posedge clk_sys);
      supply_ok <= 1'b1;
      wr(gdc_pkg::ONTIME_OFS, 32'h5);
      wr(gdc_pkg::PERIOD_OFS, 32'h10);
      wr(gdc_pkg::CTRL_OFS, 32'hB);
      cyc(2);
      chk("pin_released", 1, en_wire);
      wait_run();
      wait_lvl(1);
      wait_lvl(0);
      wait_lvl(1);
      n = 0;
      while (pwm_o === 1'b1 && n < 40) begin
         chk("hg_in_phase", 1, hg);
         cyc(1);
         n++;
      end
      chk("on_time", 5, n);
      chk("lg_opposite", 1, lg);
      rd(gdc_pkg::STATUS_OFS, 32'hB, "status_run");
   endtask
   task automatic t_zcd();
      wr(gdc_pkg::CTRL_OFS, 32'h3);
      @(posedge clk_sys);
      il_pos <= 1'b0;
      cyc(2);
      chk("zcd_pin", 0, zcd_n);
      wait_lvl(1);
      wait_lvl(0);
      chk("lg_neg_off", 0, lg);
      chk("neg_mode", 1, neg);
      @(posedge clk_sys);
      il_pos <= 1'b1;
      cyc(1);
      chk("lg_pos_on", 1, lg);
      chk("pos_mode", 0, neg);
      wr(gdc_pkg::CTRL_OFS, 32'hB);
   endtask
   task automatic t_tri();
      wr(gdc_pkg::CTRL_OFS, 32'hF);
      cyc(2);
      chk("tri_float", 0, pwm_oe);
      chk("tri_gates", 0, {hg, lg});
      wr(gdc_pkg::CTRL_OFS, 32'hB);
      cyc(2);
      chk("tri_exit", 1, pwm_oe);
      chk("exit_follow", {pwm_o, !pwm_o}, {hg, lg});
   endtask
   task automatic t_fault();
      wait_lvl(0);
      @(posedge clk_sys);
      hs_fault <= 1'b1;
      @(posedge clk_sys);
      hs_fault <= 1'b0;
      cyc(3);
      chk("fault_pin", 0, en_wire);
      chk("fault_float", 0, pwm_oe);
      rd(gdc_pkg::STATUS_OFS, 32'h5, "status_fault");
      wr(gdc_pkg::CTRL_OFS, 32'h0);
      wr(gdc_pkg::CTRL_OFS, 32'hB);
      cyc(50);
      chk("fault_kept", 0, pwm_oe);
      @(posedge clk_sys);
      supply_ok <= 1'b0;
      cyc(2);
      rd(gdc_pkg::STATUS_OFS, 32'h0, "fault_cleared");
      @(posedge clk_sys);
      supply_ok <= 1'b1;
      cyc(1);
      wait_run();
      @(posedge clk_sys);
      supply_ok <= 1'b0;
      cyc(2);
      chk("lockout_float", 0, pwm_oe);
      chk("lockout_gates", 0, {hg, lg});
   endtask
   task automatic results();
      if (error_cnt == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
      cyc(1);
      t_reset();
      t_run();
      t_zcd();
      t_tri();
      t_fault();
      results();
   end
   // two startups of 4000 cycles dominate the run
   initial begin
      #200000;
      error_cnt++;
      results();
   end
endmodule // gdc_ctrl_tb_top

// ### gdc_drv_model.sv
// behavioural model of the gate driver logic that the controller drives
// assumes window, enable and supply levels arrive pre-decoded on clk_sys
`timescale 1ns/1ps
module gdc_drv_model #(
   parameter int unsigned START = 8
) (
   input  wire logic clk_sys,
   input  wire logic supply_ok,
   input  wire logic en_wire,
   input  wire logic pwm_lvl,
   input  wire logic pwm_drv,
   input  wire logic zcd_n,
   input  wire logic il_pos,
   input  wire logic hs_fault,
   output logic      high_gate,
   output logic      low_gate,
   output logic      flt_oe,
   output logic      neg_mode
);
   logic [7:0] start_q;
   logic       latch_q;
   logic       on;
   // ---------------------------------------------------------------
   // startup and fault latch
   // ---------------------------------------------------------------
   // only a lockout clears the latch; toggling enable never does
   always_ff @(posedge clk_sys) begin
      if (!supply_ok) begin
         latch_q <= 1'b0;
         start_q <= '0;
      end else begin
         if (hs_fault && low_gate) begin
            latch_q <= 1'b1;
         end
         if (!en_wire || latch_q) begin
            start_q <= '0;
         end else if (start_q != 8'(START)) begin
            start_q <= start_q + 8'h01;
         end
      end
   end
   assign on = supply_ok && en_wire && !latch_q && start_q == 8'(START);
   // ---------------------------------------------------------------
   // gate mapping
   // ---------------------------------------------------------------
   // a floating pwm keeps both gates low at once, hold-off taken as zero
   assign high_gate = on && pwm_drv && pwm_lvl;
   assign low_gate  = on && pwm_drv && !pwm_lvl && (zcd_n || il_pos);
   assign neg_mode  = !zcd_n && !il_pos;
   assign flt_oe    = latch_q;
endmodule // gdc_drv_model

// ### gdc_pkg.sv
// gate driver controller: shared constants, register map, state codes
// assumes a 200 MHz system clock and a byte-addressed 32-bit register port
package gdc_pkg;
   // ----------------------------------------------------------------
   // register port
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] PERIOD_OFS = 8'h04;
   localparam logic [7:0] ONTIME_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0C;

   // control field positions
   localparam int unsigned CTRL_EN_BIT  = 0;
   localparam int unsigned CTRL_RUN_BIT = 1;
   localparam int unsigned CTRL_TRI_BIT = 2;
   localparam int unsigned CTRL_ZCD_BIT = 3;
   localparam int unsigned CTRL_W       = 4;

   // values after reset
   localparam logic [3:0]  CTRL_RST   = 4'h8;
   localparam logic [15:0] PERIOD_RST = 16'h00C8;
   localparam logic [15:0] ONTIME_RST = 16'h0014;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_PS  = 5000;
   localparam int unsigned STARTUP_TIME_NS = 20000;
   // least time: round up to whole cycles
   localparam int unsigned STARTUP_CYC =
      (STARTUP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned WAIT_W = 12;

   // ----------------------------------------------------------------
   // sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      GDC_OFF   = 2'b00,
      GDC_WAIT  = 2'b01,
      GDC_RUN   = 2'b10,
      GDC_FAULT = 2'b11
   } gdc_state_e;
endpackage
